// ===== bcpm_pin_mux.v
// Pin function multiplexer for the external bus control pins.
`timescale 1ns/1ps
`include "bcpm_defines.vh"
//
// Summary of operation
// - Out of reset the strobe pin is a pulled-up general-purpose input in single-chip modes; expanded modes enable the strobe.
// - Strobe drives the pin only once its enable bit is set.
// - Special expanded modes also carry the low tag on the strobe pin.
// - Strobe level is XNOR of address bit zero and access size.
// - Two queue-tracking outputs report instruction queue state, time shared.
// - Data bus enable is active low, asserted in bus clock high phase.
// - Stretched access: enable asserted only in last quarter of last cycle.
// - Expanded modes: enable active from reset, governed by select bit.
// - Single-chip modes: enable pin keeps its pull-up during and after reset.
// - Pin may instead output inverted bus clock, chosen by two select bits.
// - Calibration output is 50% duty divider clock, crystal rate at reset.
// - Data bus enable wins the shared pin over the calibration output.
// - Clearing calibration enable switches its clock off the pin.
// - Clock test out only with test enable set, queue output enable clear.
// - Mode pins sampled in reset; afterwards queue tracking or port pins.
// - Read/write pin shows bus direction in expanded modes, else port pin.
// - Bus clock is driven out as timing reference for address demux.
// - Read/write does not drive the pin until its enable bit is set.
module bcpm_pin_mux
(
  // Clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // Register port
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Internal bus core signals
  input wire bus_phase_hi,
  input wire bus_quarter_last,
  input wire bus_stretch,
  input wire bus_last_cycle,
  input wire bus_ext_access,
  input wire bus_read,
  input wire addr_bit0,
  input wire access_size_signal,
  input wire low_tag_input,
  input wire [1:0] queue_state,
  input wire clock_under_test,
  // General-purpose port drive for the shared pins
  input wire [7:0] port_out,
  input wire [7:0] port_dir,
  // Mode select pin inputs
  input wire mode_select_lo,
  input wire mode_select_hi,
  // Shared pin outputs (index 7 down to 2)
  output reg [7:0] pin_out,
  output reg [7:0] pin_oe,
  output reg [7:0] pin_pullup,
  output reg bus_clock_out,
  output reg data_bus_enable_n
);
  reg [7:0] port_assignment_reg;
  reg [7:0] div_ratio;
  reg [1:0] mode;
  reg mode_lo_s1, mode_lo_s2, mode_hi_s1, mode_hi_s2;
  reg in_reset;
  reg queue_phase;
  wire slow_divider_clock;
  reg [7:0] next_out;
  reg [7:0] next_oe;
  reg [7:0] next_pu;
  reg next_dbe_n;

  function is_expanded;
    input [1:0] m;
    begin
      is_expanded = (m == `BCPM_MODE_SPECIAL_EXP) ||
                    (m == `BCPM_MODE_NORMAL_EXP);
    end
  endfunction

  wire expanded = is_expanded(mode);
  wire bus_en_sel = port_assignment_reg[`BCPM_BIT_BUS_EN_SEL];
  wire inv_clk_sel = port_assignment_reg[`BCPM_BIT_INV_CLK_SEL];
  wire strobe_enable_bit = port_assignment_reg[`BCPM_BIT_STROBE_EN];
  wire direction_enable_bit = port_assignment_reg[`BCPM_BIT_DIR_EN];
  wire calibration_enable_bit = port_assignment_reg[`BCPM_BIT_CAL_EN];
  wire clock_test_enable_bit = port_assignment_reg[`BCPM_BIT_CLK_TEST_EN];
  wire queue_track_output_enable = port_assignment_reg[`BCPM_BIT_QUEUE_OE];

  bcpm_slow_div u_div
  (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .div_ratio(div_ratio),
    .slow_divider_clock(slow_divider_clock)
  );

  // Mode pins are asynchronous, so they are synchronised before use.
  always @(posedge clk_sys)
  begin
    mode_lo_s1 <= mode_select_lo;
    mode_lo_s2 <= mode_lo_s1;
    mode_hi_s1 <= mode_select_hi;
    mode_hi_s2 <= mode_hi_s1;
  end

  // The mode is latched on every reset cycle, so the last sample before
  // release wins. The assignment register default depends on that mode.
  always @(posedge clk_sys)
  begin
    in_reset <= sys_rst;
    if (sys_rst)
    begin
      mode <= {mode_hi_s2, mode_lo_s2};
      div_ratio <= `BCPM_DIV_RESET;
      port_assignment_reg <= 8'h00;
      queue_phase <= 1'b0;
    end
    else
    begin
      queue_phase <= ~queue_phase;
      if (in_reset)
      begin
        if (is_expanded(mode))
          port_assignment_reg <= `BCPM_PORT_ASSIGNMENT_REG_RESET_EXP;
        else
          port_assignment_reg <= `BCPM_PORT_ASSIGNMENT_REG_RESET_SC;
      end
      else if (reg_wr && reg_addr == `BCPM_ADDR_PORT_ASSIGNMENT_REG_REG)
        port_assignment_reg <= reg_wdata;
      else if (reg_wr && reg_addr == `BCPM_ADDR_DIVIDER)
        div_ratio <= reg_wdata;
    end
  end

  // Read data stands in the cycle after the strobe only.
  always @(posedge clk_sys)
  begin
    if (sys_rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      if (reg_addr == `BCPM_ADDR_PORT_ASSIGNMENT_REG_REG)
        reg_rdata <= port_assignment_reg;
      else if (reg_addr == `BCPM_ADDR_MODE)
        reg_rdata <= {6'h00, mode};
      else if (reg_addr == `BCPM_ADDR_DIVIDER)
        reg_rdata <= div_ratio;
      else if (reg_addr == `BCPM_ADDR_PIN_IN)
        reg_rdata <= {6'h00, mode_hi_s2, mode_lo_s2};
      else
        reg_rdata <= 8'h00;
    end
    else
      reg_rdata <= 8'h00;
  end

  // Pin function selection; port drive is the default for every pin.
  always @*
  begin
    next_out = port_out;
    next_oe = port_dir;
    next_pu = ~port_dir;
    // Enable is asserted in the high phase; on a stretched access only in
    // the last quarter of the final cycle.
    if (bus_stretch)
      next_dbe_n = ~(bus_ext_access && bus_last_cycle &&
                     bus_quarter_last);
    else
      next_dbe_n = ~(bus_ext_access && bus_phase_hi);
    // Deselected or single-chip, the enable stays idle so that no external
    // driver is ever switched on by a function that is not in use.
    if (bus_en_sel || !expanded)
      next_dbe_n = 1'b1;
    // Pin 7: data bus enable, inverted clock or calibration.
    if (!bus_en_sel)
    begin
      if (expanded)
      begin
        next_out[7] = next_dbe_n;
        next_oe[7] = 1'b1;
        next_pu[7] = 1'b0;
      end
      else
        next_pu[7] = 1'b1;
    end
    else if (inv_clk_sel)
    begin
      next_out[7] = ~bus_phase_hi;
      next_oe[7] = 1'b1;
      next_pu[7] = 1'b0;
    end
    else if (calibration_enable_bit)
    begin
      next_out[7] = slow_divider_clock;
      next_oe[7] = 1'b1;
      next_pu[7] = 1'b0;
    end
    else if (!expanded)
      next_pu[7] = 1'b1;
    // Pin 6: clock test or high queue track; pin 5: low queue track.
    if (clock_test_enable_bit && !queue_track_output_enable)
    begin
      next_out[6] = clock_under_test;
      next_oe[6] = 1'b1;
      next_pu[6] = 1'b0;
    end
    else if (queue_track_output_enable && expanded)
    begin
      // Two state bits are time shared over both pins.
      next_out[6] = queue_phase ? queue_state[1] : queue_state[0];
      next_out[5] = queue_phase ? queue_state[0] : queue_state[1];
      next_oe[6] = 1'b1;
      next_oe[5] = 1'b1;
      next_pu[6] = 1'b0;
      next_pu[5] = 1'b0;
    end
    // Pin 3: low-byte strobe, multiplexed with the low tag.
    if (strobe_enable_bit && expanded)
    begin
      if (mode == `BCPM_MODE_SPECIAL_EXP && !bus_ext_access)
        next_out[3] = low_tag_input;
      else
        next_out[3] = ~(addr_bit0 ^ access_size_signal);
      next_oe[3] = 1'b1;
      next_pu[3] = 1'b0;
    end
    // Pin 2: read/write direction, high for reads.
    if (direction_enable_bit && expanded)
    begin
      next_out[2] = bus_read | ~bus_ext_access;
      next_oe[2] = 1'b1;
      next_pu[2] = 1'b0;
    end
  end

  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      pin_out <= 8'h00;
      pin_oe <= 8'h00;
      pin_pullup <= 8'hff;
      bus_clock_out <= 1'b0;
      data_bus_enable_n <= 1'b1;
    end
    else
    begin
      pin_out <= next_out;
      pin_oe <= next_oe;
      pin_pullup <= next_pu;
      bus_clock_out <= bus_phase_hi;
      data_bus_enable_n <= next_dbe_n;
    end
  end
endmodule

// ===== bcpm_defines.vh
// Constants for the bus control pin multiplexer.
`ifndef BCPM_DEFINES_VH
`define BCPM_DEFINES_VH
// Port assignment register bit positions.
`define BCPM_BIT_INV_CLK_SEL 0
`define BCPM_BIT_DIR_EN 2
`define BCPM_BIT_STROBE_EN 3
`define BCPM_BIT_CLK_TEST_EN 4
`define BCPM_BIT_CAL_EN 5
`define BCPM_BIT_QUEUE_OE 6
`define BCPM_BIT_BUS_EN_SEL 7
// Register map and reset values.
`define BCPM_ADDR_PORT_ASSIGNMENT_REG_REG 4'h0
`define BCPM_ADDR_MODE 4'h1
`define BCPM_ADDR_DIVIDER 4'h2
`define BCPM_ADDR_PIN_IN 4'h3
`define BCPM_PORT_ASSIGNMENT_REG_RESET_EXP 8'h0c
`define BCPM_PORT_ASSIGNMENT_REG_RESET_SC 8'h80
`define BCPM_DIV_RESET 8'h00
// Mode codes from the two mode select pins.
`define BCPM_MODE_SPECIAL_SC 2'h0
`define BCPM_MODE_SPECIAL_EXP 2'h1
`define BCPM_MODE_NORMAL_SC 2'h2
`define BCPM_MODE_NORMAL_EXP 2'h3
`endif

// ===== bcpm_slow_div.v
// Slow-mode clock divider producing a 50% duty square wave.
`timescale 1ns/1ps
`include "bcpm_defines.vh"
module bcpm_slow_div
(
  // Clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // Control
  input wire [7:0] div_ratio,
  // Output
  output reg slow_divider_clock
);
  reg [7:0] cnt;
  // A ratio of zero toggles every cycle, half the system rate, which
  // stands for the crystal rate out of reset.
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      cnt <= 8'h00;
      slow_divider_clock <= 1'b0;
    end
    else if (cnt >= div_ratio)
    begin
      cnt <= 8'h00;
      slow_divider_clock <= ~slow_divider_clock;
    end
    else
    begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule

// ===== bcpm_pin_mux_props.sv
// Property checker for the bus control pin multiplexer.
`timescale 1ns/1ps
module bcpm_pin_mux_props
(
  // Clock, reset and register read
  input wire clk_sys,
  input wire sys_rst,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  // Causes from the core and the port
  input wire bus_phase_hi,
  input wire bus_stretch,
  input wire bus_last_cycle,
  input wire bus_quarter_last,
  input wire addr_bit0,
  input wire access_size_signal,
  input wire [7:0] port_dir,
  input wire mode_select_lo,
  input wire mode_select_hi,
  // Pin side
  input wire [7:0] pin_out,
  input wire [7:0] pin_oe,
  input wire [7:0] pin_pullup,
  input wire bus_clock_out,
  input wire data_bus_enable_n
);
  logic [1:0] m1, m2, md, age;
  wire ok = (age == 2'h3);
  // ==========================================
  // Mode strap copy and settling after release
  // The first cycles after reset still carry reset-time outputs, so skip them.
  always @(posedge clk_sys)
  begin
    m1 <= {mode_select_hi, mode_select_lo};
    m2 <= m1;
    md <= sys_rst ? m2 : md;
    age <= sys_rst ? 2'h0 : (ok ? age : age + 2'h1);
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  property p_bus_clock_out;
    ok |-> bus_clock_out == $past(bus_phase_hi);
  endproperty
  a_bus_clock_out: assert property (p_bus_clock_out) else $error("bus clock late");
  property p_dbe_hi;
    !data_bus_enable_n |-> $past(bus_phase_hi);
  endproperty
  a_dbe_hi: assert property (p_dbe_hi) else $error("enable off phase");
  property p_dbe_str;
    !data_bus_enable_n && $past(bus_stretch) |->
      $past(bus_last_cycle) && $past(bus_quarter_last);
  endproperty
  a_dbe_str: assert property (p_dbe_str) else $error("stretch enable");
  property p_rd0;
    ok && !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rd0: assert property (p_rd0) else $error("read data stands");
  property p_pull;
    ok |-> (~pin_oe & ~pin_pullup & 8'hec) == 8'h00;
  endproperty
  a_pull: assert property (p_pull) else $error("undriven pin floats");
  property p_sc_strb;
    ok && !md[0] |-> pin_oe[3] == $past(port_dir[3]);
  endproperty
  a_sc_strb: assert property (p_sc_strb) else $error("strobe pin");
  property p_sc_rw;
    ok && !md[0] |-> pin_oe[2] == $past(port_dir[2]);
  endproperty
  a_sc_rw: assert property (p_sc_rw) else $error("direction pin");
  property p_strb;
    ok && md == 2'h3 && pin_oe[3] && !$past(port_dir[3]) |->
      pin_out[3] == ($past(addr_bit0) ~^ $past(access_size_signal));
  endproperty
  a_strb: assert property (p_strb) else $error("strobe level");
  c_dbe: cover property (!data_bus_enable_n && bus_clock_out);
  c_str: cover property (!data_bus_enable_n && $past(bus_stretch));
  c_cal: cover property (ok && pin_oe[7] && data_bus_enable_n);
endmodule
bind bcpm_pin_mux bcpm_pin_mux_props u_props (.*);

// ===== bcpm_ext_bus.sv
// Model of the external bus devices and the mode straps.
`timescale 1ns/1ps
module bcpm_ext_bus
(
  // Clock, reset and strap setting
  input wire clk_sys,
  input wire sys_rst,
  input wire [1:0] mode_cfg,
  // Bus control pins
  input wire bus_clock_out,
  input wire data_bus_enable_n,
  output logic mode_select_lo = 1'b0,
  output logic mode_select_hi = 1'b0,
  output logic [7:0] read_windows = 8'h00
);
  always @(posedge clk_sys)
  begin
    if (sys_rst)
      {mode_select_hi, mode_select_lo} <= mode_cfg;
    else
      {mode_select_hi, mode_select_lo} <= ~{mode_select_hi, mode_select_lo};
    // Read drive windows are timed against the bus clock.
    if (!sys_rst && bus_clock_out && !data_bus_enable_n)
      read_windows <= read_windows + 8'h01;
  end
endmodule

// ===== tb.sv
// Testbench for the bus control pin multiplexer.
`timescale 1ns/1ps
module tb;
  logic clk_sys = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, port_out = 8'h00, port_dir = 8'h00, p;
  logic bus_phase_hi = 0, bus_quarter_last = 0, bus_stretch = 0;
  logic bus_last_cycle = 0, bus_ext_access = 1, bus_read = 1;
  logic addr_bit0 = 0, access_size_signal = 0, low_tag_input = 0;
  logic clock_under_test = 0;
  logic [1:0] queue_state = 2'h0, mode_cfg = 2'h3;
  logic [4:0] dbe_tab [5] = '{5'h10, 5'h01, 5'h19, 5'h1e, 5'h1d};
  wire [7:0] reg_rdata, pin_out, pin_oe, pin_pullup, read_windows;
  wire bus_clock_out, data_bus_enable_n, mode_select_lo, mode_select_hi;
  int n_fail = 0, total_checks = 0;
  bcpm_pin_mux DUT (.*);
  bcpm_ext_bus u_far (.*);
  always #20 clk_sys = ~clk_sys;
  // ==========================================
  // Access and comparison tasks
  task automatic ck(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic look(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    ck(reg_rdata, e);
  endtask
  task automatic reboot(input logic [1:0] m);
    @(posedge clk_sys);
    mode_cfg <= m;
    sys_rst <= 1'b1;
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    look(2);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ==========================================
  // Tests
  initial
  begin
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    look(2);
    rd(4'h0, 8'h0c);
    wr(4'h1, 8'h00);
    rd(4'h1, 8'h03);
    wr(4'h9, 8'h5a);
    rd(4'h9, 8'h00);
    $display("registers done");
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_sys);
      {access_size_signal, addr_bit0} <= i[1:0];
      look(1);
      ck(pin_oe & 8'h08, 8'h08);
      ck(pin_out & 8'h08, (i[0] ~^ i[1]) ? 8'h08 : 8'h00);
    end
    foreach (dbe_tab[i])
    begin
      @(posedge clk_sys);
      {bus_phase_hi, bus_stretch, bus_last_cycle, bus_quarter_last}
        <= dbe_tab[i][4:1];
      look(1);
      ck({7'h00, data_bus_enable_n}, {7'h00, dbe_tab[i][0]});
    end
    ck({7'h00, read_windows != 8'h00}, 8'h01);
    $display("strobe and enable done");
    wr(4'h0, 8'h2c);
    bus_stretch <= 1'b0;
    look(1);
    ck({7'h00, data_bus_enable_n}, 8'h00);
    ck(pin_oe & ~pin_out & 8'h80, 8'h80);
    wr(4'h0, 8'ha0);
    look(1);
    p = pin_out;
    look(0);
    ck((pin_out ^ p) & 8'h80, 8'h80);
    ck({pin_oe[7], data_bus_enable_n}, 2'h3);
    wr(4'h0, 8'h80);
    look(1);
    ck((pin_oe | ~pin_pullup) & 8'h80, 8'h00);
    wr(4'h0, 8'h81);
    look(1);
    ck(pin_oe & ~pin_out & 8'h80, 8'h80);
    wr(4'h0, 8'h10);
    clock_under_test <= 1'b1;
    look(1);
    ck(pin_oe & pin_out & 8'h40, 8'h40);
    wr(4'h0, 8'h40);
    queue_state <= 2'h1;
    look(1);
    ck(pin_oe & 8'h60, 8'h60);
    ck({7'h00, pin_out[6] ^ pin_out[5]}, 8'h01);
    wr(4'h0, 8'h00);
    look(1);
    ck(pin_oe & 8'h0c, 8'h00);
    $display("pin functions done");
    reboot(2'h2);
    rd(4'h0, 8'h80);
    ck(pin_pullup & 8'h8c, 8'h8c);
    wr(4'h0, 8'h0c);
    look(1);
    ck(pin_oe & 8'h0c, 8'h00);
    $display("single chip done");
    reboot(2'h1);
    @(posedge clk_sys);
    {bus_ext_access, low_tag_input} <= 2'h0;
    look(1);
    ck(pin_oe & ~pin_out & 8'h08, 8'h08);
    $display("special expanded done");
    test_done;
  end
  initial
  begin
    #400000;
    n_fail++;
    test_done;
  end
endmodule
